// [rtl/bridge_fault_pkg.sv]
package bridge_fault_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEGLITCH_NS = 5000;
  localparam int SLEEP_PULSE_MAX_NS = 20000;
  localparam int RETRY_NS = 4000;
  // Least times round up, longest times round down
  localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int SLEEP_CYC = SLEEP_PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int RETRY_CYC = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = 3;
  localparam int CNT_W = 8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h0c;

  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam int CTL_TSD_AUTO = 0;
  localparam int CTL_WARNING_REPORT_ENABLE = 1;
  localparam int CTL_PUMP_UNDERVOLTAGE_DIS = 2;
  localparam int CTL_OCP_LO = 3;
  localparam int CTL_OCP_HI = 4;
  localparam int CTL_OLP = 5;
  localparam int CTL_OLA = 6;
  localparam int CTL_OPENLOAD_DELAY_SELECT = 7;
  localparam int CTL_CURRENT_LIMIT_REPORT = 8;
  localparam int CTL_FORCE_HIZ = 9;
  localparam int CMD_CLEAR = 0;

  localparam int ST_FAULT = 0;
  localparam int ST_TSD = 1;
  localparam int ST_OTW = 2;
  localparam int ST_SUPPLY_UNDERVOLTAGE = 3;
  localparam int ST_PUMP_UNDERVOLTAGE = 4;
  localparam int ST_OCP = 5;
  localparam int ST_OL = 6;
  localparam int ST_ITRIP = 7;
  localparam int ST_HIZ = 8;
  localparam int ST_MODE_LO = 9;
  localparam int ST_MODE_HI = 11;
  localparam int ST_PIN_CFG = 12;
  localparam int ST_ASLEEP = 13;
  localparam int CFG_SLEW_LO = 10;
  localparam int CFG_SLEW_HI = 19;
  localparam int CFG_ITRIP_LO = 20;
  localparam int CFG_ITRIP_HI = 27;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] OCP_LATCH = 2'h0;
  localparam logic [1:0] OCP_RETRY = 2'h1;
  localparam logic [1:0] OCP_REPORT = 2'h2;
  localparam logic [1:0] OCP_OFF = 2'h3;
  localparam logic OPENLOAD_DELAY_SELECT_300US = 1'b1;
  localparam logic [7:0] ITRIP_6A5 = 8'h41;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Slew rate in tenths of a volt per microsecond
  localparam logic [9:0] SLEW_GND = 10'h214;
  localparam logic [9:0] SLEW_22K = 10'h154;
  localparam logic [9:0] SLEW_68K = 10'h0b7;
  localparam logic [9:0] SLEW_OPEN = 10'h082;
  localparam logic [9:0] SLEW_51K_UP = 10'h04f;
  localparam logic [9:0] SLEW_SUPPLY = 10'h01a;

  typedef enum logic [2:0] {
    MODE_PHEN = 3'b001,
    MODE_PWM = 3'b010,
    MODE_INDEP = 3'b100
  } ctrl_mode_t;
endpackage : bridge_fault_pkg

// [rtl/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : pin_sync

// [rtl/sleep_pulse.sv]
`timescale 1ns/10ps
module sleep_pulse
  import bridge_fault_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Synchronised sleep pin
  input wire logic sleep_n_sync,
  // Events
  output logic clear_pulse_ff,
  output logic wake_pulse_ff,
  output logic asleep_ff
);
  logic [CNT_W-1:0] low_cnt_ff;
  wire low_long = low_cnt_ff >= CNT_W'(SLEEP_CYC);
  wire low_valid = low_cnt_ff >= CNT_W'(DEGLITCH_CYC);

  // Counter saturates, so a long sleep never wraps into a short pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_ff <= '0;
      clear_pulse_ff <= 1'b0;
      wake_pulse_ff <= 1'b0;
      asleep_ff <= 1'b0;
    end else if (!sleep_n_sync) begin
      low_cnt_ff <= low_long ? low_cnt_ff : low_cnt_ff + CNT_W'(1);
      clear_pulse_ff <= 1'b0;
      wake_pulse_ff <= 1'b0;
      asleep_ff <= low_long;
    end else begin
      low_cnt_ff <= '0;
      clear_pulse_ff <= low_valid;
      wake_pulse_ff <= asleep_ff;
      asleep_ff <= 1'b0;
    end
  end
endmodule : sleep_pulse

// [rtl/bridge_fault_response.sv]
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module bridge_fault_response
  import bridge_fault_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Fault detector inputs
  input wire logic die_overtemp,
  input wire logic overtemp_warning,
  input wire logic supply_undervoltage,
  input wire logic pump_undervoltage,
  input wire logic overcurrent,
  input wire logic openload_detect,
  input wire logic current_trip,
  // Configuration pins
  input wire logic sleep_n_pin,
  input wire logic pin_config_strap,
  input wire logic mode_pin_high,
  input wire logic mode_pin_low,
  input wire logic current_limit_enable_n,
  input wire logic openload_disable_n,
  input wire logic [2:0] slew_select_pin,
  // Driver controls
  output logic fault_indicator_n,
  output logic bridge_outputs_hiz,
  output logic logic_reset,
  output logic pump_enable,
  output logic [2:0] control_mode,
  output logic [9:0] slew_rate,
  output logic [7:0] current_limit_level,
  output logic passive_openload_enable,
  output logic active_openload_check,
  output logic openload_delay_select
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = a[7:2] == off[7:2];
  endfunction : hit

  function automatic logic [9:0] slew_decode(input logic [2:0] lvl);
    case (lvl)
      3'h0: slew_decode = SLEW_GND;
      3'h1: slew_decode = SLEW_22K;
      3'h2: slew_decode = SLEW_68K;
      3'h4: slew_decode = SLEW_51K_UP;
      3'h5: slew_decode = SLEW_SUPPLY;
      default: slew_decode = SLEW_OPEN;
    endcase
  endfunction : slew_decode

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [15:0] pins_sync;
  logic t_ot, t_warn, t_uv, t_pump_undervoltage, t_oc, t_ol, t_itrip, sleep_n_sync;
  logic strap_sync, mode_hi_sync, mode_lo_sync, itrip_n_sync, ol_n_sync;
  logic [2:0] slew_sync;

  pin_sync #(.W(16)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({die_overtemp, overtemp_warning, supply_undervoltage,
        pump_undervoltage, overcurrent, openload_detect, current_trip,
        sleep_n_pin, pin_config_strap, mode_pin_high, mode_pin_low,
        current_limit_enable_n, openload_disable_n, slew_select_pin}),
    .q(pins_sync)
  );

  assign {t_ot, t_warn, t_uv, t_pump_undervoltage, t_oc, t_ol, t_itrip, sleep_n_sync,
          strap_sync, mode_hi_sync, mode_lo_sync, itrip_n_sync, ol_n_sync,
          slew_sync} = pins_sync;

  logic sleep_clear, wake, asleep;

  sleep_pulse u_sleep (
    .clk(clk),
    .rst(rst),
    .sleep_n_sync(sleep_n_sync),
    .clear_pulse_ff(sleep_clear),
    .wake_pulse_ff(wake),
    .asleep_ff(asleep)
  );

  // ----------------------------------------
  // Variant strap and mode latch
  // ----------------------------------------
  logic [1:0] settle_cnt_ff;
  logic strap_done_ff, pin_cfg_ff;
  ctrl_mode_t mode_ff;
  wire settle_end = settle_cnt_ff == 2'(SETTLE_CYC - 1);
  wire settled = settle_cnt_ff == 2'(SETTLE_CYC);
  wire ctrl_mode_t mode_pin_dec = ctrl_mode_t'(mode_lo_sync ? MODE_PHEN :
                                  mode_hi_sync ? MODE_PWM : MODE_INDEP);

  // Wait for the synchronisers to fill before trusting pin levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_cnt_ff <= '0;
      strap_done_ff <= 1'b0;
      pin_cfg_ff <= 1'b0;
      mode_ff <= MODE_PHEN;
    end else begin
      if (wake) begin
        settle_cnt_ff <= '0;
      end else if (!settled) begin
        settle_cnt_ff <= settle_cnt_ff + 2'h1;
      end
      if (settle_end && !strap_done_ff) begin
        pin_cfg_ff <= strap_sync;
        strap_done_ff <= 1'b1;
      end
      if (settle_end) begin
        mode_ff <= mode_pin_dec;
      end
    end
  end

  // ----------------------------------------
  // Control register and effective settings
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl_ff;
  logic clear_cmd_ff;
  wire ol_pin_en = !ol_n_sync;
  wire itrip_pin_en = !itrip_n_sync;
  // Pin variant ignores software settings and uses fixed values or its own pins
  wire eff_tsd_auto = pin_cfg_ff | ctrl_ff[CTL_TSD_AUTO];
  wire eff_warning_report_enable = !pin_cfg_ff & ctrl_ff[CTL_WARNING_REPORT_ENABLE];
  wire eff_pump_undervoltage_dis = !pin_cfg_ff & ctrl_ff[CTL_PUMP_UNDERVOLTAGE_DIS];
  wire [1:0] eff_ocp = pin_cfg_ff ? OCP_LATCH :
                       ctrl_ff[CTL_OCP_HI:CTL_OCP_LO];
  wire eff_olp = pin_cfg_ff ? ol_pin_en : ctrl_ff[CTL_OLP];
  wire eff_ola = pin_cfg_ff ? ol_pin_en : ctrl_ff[CTL_OLA];
  wire eff_openload_delay_select = pin_cfg_ff ? OPENLOAD_DELAY_SELECT_300US : ctrl_ff[CTL_OPENLOAD_DELAY_SELECT];
  wire eff_current_limit_report = !pin_cfg_ff & ctrl_ff[CTL_CURRENT_LIMIT_REPORT];
  wire eff_force_hiz = !pin_cfg_ff & ctrl_ff[CTL_FORCE_HIZ];
  wire [7:0] eff_itrip_lvl = (pin_cfg_ff && !itrip_pin_en) ? 8'h00 :
                             ITRIP_6A5;

  // ----------------------------------------
  // Fault state
  // ----------------------------------------
  logic tsd_flag_ff, tsd_hold_ff, ocp_latch_ff, ol_latch_ff, fault_flag_ff;
  logic otw_flag_ff;
  logic [CNT_W-1:0] retry_cnt_ff;
  // Supply undervoltage resets the latched state like a clear
  wire clr = clear_cmd_ff | sleep_clear | wake | t_uv;
  wire pump_undervoltage_rep = t_pump_undervoltage & !eff_pump_undervoltage_dis;
  wire oc_latch_set = t_oc & (eff_ocp == OCP_LATCH);
  wire retry_active = retry_cnt_ff != '0;
  wire retry_start = t_oc & (eff_ocp == OCP_RETRY) & !retry_active;
  wire oc_rep = t_oc & (eff_ocp != OCP_OFF);
  wire ol_set = t_ol & (eff_olp | eff_ola);
  wire warn_rep = t_warn & eff_warning_report_enable;
  wire current_limit_report = t_itrip & eff_current_limit_report;
  wire report_now = t_ot | t_uv | pump_undervoltage_rep | oc_rep | warn_rep | current_limit_report |
                    retry_active;
  wire fault_any = report_now | tsd_hold_ff | ocp_latch_ff |
                   ol_latch_ff;
  // Latched thermal hold drops only once the die has cooled
  wire nxt_tsd_hold = (t_ot & !eff_tsd_auto) |
                      (tsd_hold_ff & !(clr & !t_ot));
  wire nxt_hiz = t_ot | nxt_tsd_hold | t_uv | pump_undervoltage_rep | oc_latch_set |
                 ocp_latch_ff | retry_start | retry_active | eff_force_hiz |
                 asleep;
  wire [CNT_W-1:0] nxt_retry_cnt = retry_start ? CNT_W'(RETRY_CYC) :
                                   retry_active ? retry_cnt_ff - CNT_W'(1) :
                                   retry_cnt_ff;

  // Set wins over clear on every latched flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tsd_flag_ff <= 1'b0;
      tsd_hold_ff <= 1'b0;
      ocp_latch_ff <= 1'b0;
      ol_latch_ff <= 1'b0;
      fault_flag_ff <= 1'b0;
      otw_flag_ff <= 1'b0;
      retry_cnt_ff <= '0;
    end else begin
      tsd_flag_ff <= t_ot | (tsd_flag_ff & !clr);
      tsd_hold_ff <= nxt_tsd_hold;
      ocp_latch_ff <= oc_latch_set | (ocp_latch_ff & !clr);
      ol_latch_ff <= ol_set | (ol_latch_ff & !clr);
      fault_flag_ff <= fault_any | (fault_flag_ff & !clr);
      otw_flag_ff <= t_warn;
      retry_cnt_ff <= nxt_retry_cnt;
    end
  end

  // ----------------------------------------
  // Driver outputs
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_indicator_n <= 1'b1;
      bridge_outputs_hiz <= 1'b1;
      logic_reset <= 1'b0;
      pump_enable <= 1'b0;
      control_mode <= MODE_PHEN;
      slew_rate <= SLEW_OPEN;
      current_limit_level <= ITRIP_6A5;
      passive_openload_enable <= 1'b0;
      active_openload_check <= 1'b0;
      openload_delay_select <= 1'b0;
    end else begin
      fault_indicator_n <= !fault_any;
      bridge_outputs_hiz <= nxt_hiz;
      logic_reset <= t_uv;
      pump_enable <= !asleep;
      control_mode <= mode_ff;
      slew_rate <= slew_decode(slew_sync);
      current_limit_level <= eff_itrip_lvl;
      passive_openload_enable <= eff_olp;
      active_openload_check <= eff_ola;
      openload_delay_select <= eff_openload_delay_select;
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_got_ff, w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_got_ff & w_got_ff & !s_axi_bvalid;
  wire wr_ctrl = do_write & hit(awaddr_ff, ADDR_CTRL);
  wire wr_cmd = do_write & hit(awaddr_ff, ADDR_CMD);
  wire [CTRL_W-1:0] ctrl_wmask = {{(CTRL_W-8){wstrb_ff[1]}},
                                  {8{wstrb_ff[0]}}};
  wire [CTRL_W-1:0] nxt_ctrl = (ctrl_ff & ~ctrl_wmask) |
                               (wdata_ff[CTRL_W-1:0] & ctrl_wmask);
  wire [31:0] status_word = {18'h0, asleep, pin_cfg_ff, mode_ff,
                             !fault_indicator_n && bridge_outputs_hiz,
                             t_itrip, ol_latch_ff, ocp_latch_ff | t_oc,
                             t_pump_undervoltage, t_uv, otw_flag_ff, tsd_flag_ff,
                             fault_flag_ff};
  wire [31:0] cfg_word = {4'h0, current_limit_level, slew_rate,
                          eff_force_hiz, eff_current_limit_report, eff_openload_delay_select, eff_ola,
                          eff_olp, eff_ocp, eff_pump_undervoltage_dis, eff_warning_report_enable,
                          eff_tsd_auto};
  wire rd_ok = hit(s_axi_araddr, ADDR_CTRL) | hit(s_axi_araddr, ADDR_CMD) |
               hit(s_axi_araddr, ADDR_STATUS) | hit(s_axi_araddr, ADDR_CFG);
  wire [31:0] rd_word = hit(s_axi_araddr, ADDR_CTRL) ?
                          {{(32-CTRL_W){1'b0}}, ctrl_ff} :
                        hit(s_axi_araddr, ADDR_STATUS) ? status_word :
                        hit(s_axi_araddr, ADDR_CFG) ? cfg_word : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ctrl | wr_cmd) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
      clear_cmd_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= nxt_ctrl;
      end
      clear_cmd_ff <= wr_cmd & wstrb_ff[0] & wdata_ff[CMD_CLEAR];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence oc_retry_s;
    t_oc && eff_ocp == OCP_RETRY && !retry_active;
  endsequence

  sequence ol_found_s;
    t_ol && (eff_olp || eff_ola);
  endsequence

  tsd_shutdown_a: assert property (
    t_ot |=> bridge_outputs_hiz && !fault_indicator_n && tsd_flag_ff &&
      fault_flag_ff && (pump_enable == !$past(asleep)))
    else $error("thermal shutdown response missing");

  tsd_always_a: assert property (
    t_ot |=> bridge_outputs_hiz && tsd_flag_ff)
    else $error("thermal shutdown was disabled");

  tsd_latched_a: assert property (
    tsd_hold_ff && !t_ot && !clr |=> tsd_hold_ff && bridge_outputs_hiz)
    else $error("latched thermal hold released without clear");

  tsd_auto_a: assert property (
    !t_ot && eff_tsd_auto && !tsd_hold_ff && tsd_flag_ff && !clr
      |=> tsd_flag_ff && !tsd_hold_ff)
    else $error("auto recovery flag handling wrong");

  warn_follow_a: assert property (
    ##1 otw_flag_ff == $past(t_warn))
    else $error("warning flag not following detector");

  warn_report_a: assert property (
    t_warn && eff_warning_report_enable |=> !fault_indicator_n && fault_flag_ff)
    else $error("warning not reported");

  supply_uv_a: assert property (
    t_uv |=> logic_reset && bridge_outputs_hiz && !fault_indicator_n)
    else $error("supply undervoltage response missing");

  oc_retry_a: assert property (
    oc_retry_s |=> bridge_outputs_hiz [*8] ##1 retry_active)
    else $error("overcurrent retry window too short");

  ol_latch_a: assert property (
    ol_found_s ##1 !clr |=> !fault_indicator_n)
    else $error("open load not held");

  pin_fixed_a: assert property (
    pin_cfg_ff |-> eff_ocp == OCP_LATCH && eff_tsd_auto && !eff_pump_undervoltage_dis)
    else $error("pin variant settings not fixed");

  mode_hold_a: assert property (
    settled && !wake |=> $stable(mode_ff))
    else $error("mode changed after latch");

  fault_pin_a: assert property (
    fault_any |=> !fault_indicator_n)
    else $error("fault pin not asserted");
endmodule : bridge_fault_response

// [verification/host_ctrl.sv]
`timescale 1ns/10ps
module host_ctrl (
  // Clock
  input wire logic clk,
  // Pins
  input wire logic fault_indicator_n,
  output logic sleep_n_pin
);
  initial sleep_n_pin = 1'b1;
  // Low for cyc cycles: a clear pulse past the deglitch time, or a sleep when long enough
  task automatic pulse(input int cyc);
    @(posedge clk);
    sleep_n_pin <= 1'b0;
    repeat (cyc) @(posedge clk);
    sleep_n_pin <= 1'b1;
  endtask : pulse
  // Host polls the fault line for a bounded time before reacting
  task automatic wait_fault(input int lim, output bit seen);
    int n;
    n = 0;
    seen = 0;
    while (!seen && n < lim) begin
      @(posedge clk);
      seen = fault_indicator_n === 1'b0;
      n++;
    end
  endtask : wait_fault
endmodule : host_ctrl

// [verification/tb_bridge_fault_response.sv]
`timescale 1ns/10ps
module tb_bridge_fault_response;
  import bridge_fault_pkg::*;
  logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, br;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, fault_indicator_n, bridge_outputs_hiz, logic_reset;
  logic pump_enable, sleep_n_pin, passive_openload_enable;
  logic active_openload_check, openload_delay_select;
  logic die_overtemp = 0, overtemp_warning = 0, supply_undervoltage = 0;
  logic pump_undervoltage = 0, overcurrent = 0, openload_detect = 0;
  logic current_trip = 0, pin_config_strap = 0, mode_pin_high = 0;
  logic mode_pin_low = 1, current_limit_enable_n = 0;
  logic openload_disable_n = 1;
  logic [2:0] slew_select_pin = 0, control_mode;
  logic [9:0] slew_rate;
  logic [7:0] current_limit_level;
  int n_fail = 0, n_tests = 0, cyc = 0;
  always #50 clk = ~clk;
  bridge_fault_response i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .die_overtemp,
    .overtemp_warning, .supply_undervoltage, .pump_undervoltage,
    .overcurrent, .openload_detect, .current_trip, .sleep_n_pin,
    .pin_config_strap, .mode_pin_high, .mode_pin_low,
    .current_limit_enable_n, .openload_disable_n, .slew_select_pin,
    .fault_indicator_n, .bridge_outputs_hiz, .logic_reset, .pump_enable,
    .control_mode, .slew_rate, .current_limit_level,
    .passive_openload_enable, .active_openload_check,
    .openload_delay_select);
  host_ctrl i_host (.clk(clk), .fault_indicator_n(fault_indicator_n),
    .sleep_n_pin(sleep_n_pin));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic pins(input logic f, h);
    chk("fault_n", fault_indicator_n, f);
    chk("hiz", bridge_outputs_hiz, h);
  endtask : pins
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tsd_latched();
    axw(ADDR_CTRL, 32'h1fe);
    die_overtemp <= 1'b1;
    wt(10);
    pins(1'b0, 1'b1);
    chk("pump", pump_enable, 1'b1);
    die_overtemp <= 1'b0;
    wt(10);
    pins(1'b0, 1'b1);
    axw(ADDR_CMD, 32'h1);
    wt(5);
    pins(1'b1, 1'b0);
    $display("tsd_latched done");
  endtask : tsd_latched
  task automatic tsd_auto();
    logic [1:0] rs;
    axw(ADDR_CTRL, 32'h1);
    die_overtemp <= 1'b1;
    wt(10);
    pins(1'b0, 1'b1);
    die_overtemp <= 1'b0;
    wt(10);
    pins(1'b1, 1'b0);
    axr(ADDR_STATUS, rs);
    chk("tsd_flag", rd[ST_TSD], 1'b1);
    i_host.pulse(100);
    wt(10);
    axr(ADDR_STATUS, rs);
    chk("tsd_clr", rd[ST_TSD], 1'b0);
    $display("tsd_auto done");
  endtask : tsd_auto
  task automatic warning();
    logic [1:0] rs;
    axw(ADDR_CTRL, 32'h0);
    overtemp_warning <= 1'b1;
    wt(10);
    pins(1'b1, 1'b0);
    axr(ADDR_STATUS, rs);
    chk("otw", rd[ST_OTW], 1'b1);
    axw(ADDR_CTRL, 32'h2);
    wt(5);
    pins(1'b0, 1'b0);
    overtemp_warning <= 1'b0;
    wt(10);
    pins(1'b1, 1'b0);
    $display("warning done");
  endtask : warning
  task automatic ocp_modes();
    for (int m = 0; m < 4; m++) begin
      axw(ADDR_CTRL, 32'(m) << 3);
      overcurrent <= 1'b1;
      wt(10);
      pins(m == 3, m < 2);
      overcurrent <= 1'b0;
      wt(60);
      pins(m != 0, m == 0);
      axw(ADDR_CMD, 32'h1);
      wt(5);
    end
    $display("ocp_modes done");
  endtask : ocp_modes
  task automatic undervolt();
    logic [1:0] rs;
    pump_undervoltage <= 1'b1;
    axw(ADDR_CTRL, 32'h0);
    wt(5);
    pins(1'b0, 1'b1);
    axw(ADDR_CTRL, 32'h4);
    wt(5);
    pins(1'b1, 1'b0);
    pump_undervoltage <= 1'b0;
    supply_undervoltage <= 1'b1;
    wt(10);
    pins(1'b0, 1'b1);
    chk("lreset", logic_reset, 1'b1);
    supply_undervoltage <= 1'b0;
    wt(10);
    chk("lreset", logic_reset, 1'b0);
    axr(8'h40, rs);
    chk("rresp", rs, RESP_SLVERR);
    axw(ADDR_STATUS, 32'h0);
    chk("bresp", br, RESP_SLVERR);
    $display("undervolt done");
  endtask : undervolt
  task automatic openload_itrip();
    bit seen;
    axw(ADDR_CTRL, 32'h120);
    openload_detect <= 1'b1;
    wt(10);
    chk("olp_en", passive_openload_enable, 1'b1);
    openload_detect <= 1'b0;
    wt(10);
    pins(1'b0, 1'b0);
    i_host.wait_fault(20, seen);
    chk("host_seen", seen, 1'b1);
    i_host.pulse(100);
    wt(10);
    pins(1'b1, 1'b0);
    current_trip <= 1'b1;
    wt(10);
    pins(1'b0, 1'b0);
    current_trip <= 1'b0;
    wt(10);
    pins(1'b1, 1'b0);
    $display("openload_itrip done");
  endtask : openload_itrip
  task automatic pin_variant();
    rst <= 1'b1;
    pin_config_strap <= 1'b1;
    mode_pin_low <= 1'b0;
    mode_pin_high <= 1'b1;
    slew_select_pin <= 3'h1;
    openload_disable_n <= 1'b0;
    wt(12);
    rst <= 1'b0;
    wt(8);
    chk("mode", control_mode, MODE_PWM);
    chk("slew", slew_rate, SLEW_22K);
    chk("itrip_lvl", current_limit_level, ITRIP_6A5);
    chk("ola", active_openload_check, 1'b1);
    chk("oldly", openload_delay_select, OPENLOAD_DELAY_SELECT_300US);
    mode_pin_high <= 1'b0;
    current_limit_enable_n <= 1'b1;
    axw(ADDR_CTRL, 32'h200);
    wt(5);
    chk("mode_hold", control_mode, MODE_PWM);
    chk("itrip_off", current_limit_level, 8'h00);
    pins(1'b1, 1'b0);
    die_overtemp <= 1'b1;
    wt(10);
    die_overtemp <= 1'b0;
    wt(10);
    pins(1'b1, 1'b0);
    i_host.pulse(250);
    wt(12);
    chk("mode_wake", control_mode, MODE_INDEP);
    $display("pin_variant done");
  endtask : pin_variant
  task automatic print_verdict();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    wt(12);
    rst <= 1'b0;
    wt(5);
    pins(1'b1, 1'b0);
    tsd_latched();
    tsd_auto();
    warning();
    ocp_modes();
    undervolt();
    openload_itrip();
    pin_variant();
    print_verdict();
  end
endmodule : tb_bridge_fault_response
